// [src/sfp_pins.sv]
// serial flash pin interface: shift in, single and dual shift out, pause, protect
// Notes on behaviour
// - output bits change only on the falling serial clock edge
// - dual read drives both lines, two bits on every falling edge
// - data output floats whenever select is high
// - while paused, clock edges and input data are ignored and output floats
// - pausing leaves any running self-timed operation untouched
// - pausing neither deselects nor resets, partial command state is kept
// - write protect is active low and reads unasserted when left open
// - pause input is active low and reads inactive when left open
// - input line is sampled on every rising serial clock edge except while paused or in the dual output phase
`timescale 1ns/1ps
`default_nettype none

module sfp_pins
    import sfp_pkg::*;
#(
    parameter int OP_CYCLES = `SFP_OP_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            sck,
    input  wire logic            cs_n,
    input  wire logic            hold_n,
    input  wire logic            wp_n,
    input  wire logic            dual_line_lower_i,
    output var  logic            dual_line_lower_o,
    output var  logic            dual_line_lower_oe_n,
    input  wire logic            dual_line_upper_i,
    output var  logic            dual_line_upper_o,
    output var  logic            dual_line_upper_oe_n,
    input  wire logic            out_mode,
    input  wire logic            dual_mode,
    input  wire sfp_byte_t       tx_data,
    input  wire logic            tx_valid,
    output var  logic            tx_ready,
    output var  sfp_byte_t       rx_data,
    output var  logic            rx_valid,
    output var  logic            tx_underrun,
    output var  logic            frame_start,
    output var  logic            frame_end,
    output var  logic            selected,
    output var  logic            paused,
    output var  logic            wp_lock,
    input  wire logic            op_start,
    output var  logic            op_busy
);

    // ---------------- shared wiring ----------------
    sfp_strm_if #(.W(`SFP_BYTE_W)) tx_in_if ();
    sfp_strm_if #(.W(`SFP_BYTE_W)) tx_out_if ();

    sfp_link_st_t st_q;
    logic [2:0]   cnt_q;
    sfp_byte_t    rx_sh_q;
    sfp_byte_t    tx_sh_q;
    sfp_byte_t    rx_byte_q;
    logic         rx_tog_q;
    logic         ur_tog_q;
    logic         frame_rst;
    logic         run;
    logic         byte_end;
    logic         rx_side;
    logic         load_tx;
    logic [1:0]   mode_s;
    logic         out_mode_s;
    logic         dual_mode_s;
    sfp_byte_t    rx_next;

    logic         up_o_q;
    logic         up_oe_n_q;
    logic         lo_o_q;
    logic         lo_oe_n_q;

    // the upper line is only ever driven by us; its input half is unused
    logic         unused_upper_in;
    assign unused_upper_in = dual_line_upper_i;

    // ---------------- user side into the fifo ----------------
    assign tx_in_if.valid = tx_valid;
    assign tx_in_if.data  = tx_data;
    assign tx_ready       = tx_in_if.ready;

    sfp_afifo #(
        .W     (`SFP_BYTE_W),
        .DEPTH (`SFP_FIFO_DEPTH)
    ) u_tx_fifo (
        .wr_clk (clk),
        .rd_clk (sck),
        .rst    (rst),
        .wr     (tx_in_if),
        .rd     (tx_out_if)
    );

    // mode levels are set up before a frame; the serial clock runs only in frames,
    // so they must be stable for a few command edges before the data phase
    sfp_sync #(
        .W       (2),
        .RST_VAL (`SFP_MODE_SYNC_RST)
    ) u_mode_sync (
        .clk (sck),
        .rst (rst),
        .d   ({out_mode, dual_mode}),
        .q   (mode_s)
    );

    assign out_mode_s  = mode_s[1];
    assign dual_mode_s = mode_s[0];

    // ---------------- link side, serial clock domain ----------------
    // select high ends the frame at once; the pause pin does not reset anything
    assign frame_rst = rst | cs_n;
    assign run       = hold_n;
    assign byte_end  = cnt_q == sfp_last_bit(st_q == SFP_LK_TX2);
    assign rx_side   = st_q != SFP_LK_TX2;
    assign load_tx   = run & byte_end & out_mode_s & tx_out_if.valid;
    assign rx_next   = {rx_sh_q[`SFP_BYTE_W-2:0], dual_line_lower_i};

    // the fifo is popped only at a byte boundary, so back-pressure stalls the user
    assign tx_out_if.ready = run & byte_end & out_mode_s;

    // bit position in the current byte; frozen while paused so it resumes in place
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_q <= 3'h0;
        end else if (run) begin
            cnt_q <= byte_end ? 3'h0 : cnt_q + 3'h1;
        end
    end

    // byte phase: receive, or send one byte single or dual wide
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            st_q <= SFP_LK_RX;
        end else if (run && byte_end) begin
            if (load_tx) begin
                st_q <= dual_mode_s ? SFP_LK_TX2 : SFP_LK_TX1;
            end else begin
                st_q <= SFP_LK_RX;
            end
        end
    end

    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_sh_q <= '0;
        end else if (load_tx) begin
            tx_sh_q <= tx_out_if.data;
        end
    end

    // input line sampled on the rising edge; in dual phase it is our output
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            rx_sh_q <= '0;
        end else if (run && rx_side) begin
            rx_sh_q <= rx_next;
        end
    end

    // whole received bytes cross to the system clock by a toggle; the byte holds
    // for at least a full byte time, far longer than the synchroniser latency
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            rx_byte_q <= '0;
            rx_tog_q  <= 1'b0;
        end else if (run && byte_end && rx_side) begin
            rx_byte_q <= rx_next;
            rx_tog_q  <= ~rx_tog_q;
        end
    end

    // data phase asked for but nothing queued: report and keep receiving
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            ur_tog_q <= 1'b0;
        end else if (run && byte_end && out_mode_s && !tx_out_if.valid) begin
            ur_tog_q <= ~ur_tog_q;
        end
    end

    // output lines change on the falling edge only; the bit index follows the
    // position left by the previous rising edge
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            up_o_q    <= 1'b0;
            lo_o_q    <= 1'b0;
            up_oe_n_q <= 1'b1;
            lo_oe_n_q <= 1'b1;
        end else if (run) begin
            unique case (st_q)
                SFP_LK_RX: begin
                    up_oe_n_q <= 1'b1;
                    lo_oe_n_q <= 1'b1;
                end
                SFP_LK_TX1: begin
                    up_o_q    <= tx_sh_q[~cnt_q];
                    up_oe_n_q <= 1'b0;
                    lo_oe_n_q <= 1'b1;
                end
                SFP_LK_TX2: begin
                    up_o_q    <= tx_sh_q[{~cnt_q[1:0], 1'b1}];
                    lo_o_q    <= tx_sh_q[{~cnt_q[1:0], 1'b0}];
                    up_oe_n_q <= 1'b0;
                    lo_oe_n_q <= 1'b0;
                end
                default: begin
                    up_oe_n_q <= 1'b1;
                    lo_oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // the float has to follow the pins at once, not wait for a clock edge that a
    // paused or deselected host never gives, hence the gating after the flops
    assign dual_line_upper_o    = up_o_q;
    assign dual_line_lower_o    = lo_o_q;
    assign dual_line_upper_oe_n = up_oe_n_q | cs_n | ~hold_n;
    assign dual_line_lower_oe_n = lo_oe_n_q | cs_n | ~hold_n;

    // ---------------- system clock domain ----------------
    logic [4:0] pin_s;
    logic       rx_tog_s;
    logic       ur_tog_s;
    logic       cs_n_s;
    logic       hold_n_s;
    logic       wp_n_s;
    logic       rx_seen_q;
    logic       ur_seen_q;
    logic [$clog2(OP_CYCLES+1)-1:0] op_cnt_q;

    // open pins read high (pulled up): no lock and no pause
    sfp_sync #(
        .W       (5),
        .RST_VAL (`SFP_PIN_SYNC_RST)
    ) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .d   ({rx_tog_q, ur_tog_q, cs_n, hold_n, wp_n}),
        .q   (pin_s)
    );

    assign rx_tog_s = pin_s[4];
    assign ur_tog_s = pin_s[3];
    assign cs_n_s   = pin_s[2];
    assign hold_n_s = pin_s[1];
    assign wp_n_s   = pin_s[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_seen_q <= 1'b0;
            rx_valid  <= 1'b0;
            rx_data   <= '0;
        end else begin
            rx_seen_q <= rx_tog_s;
            rx_valid  <= rx_tog_s ^ rx_seen_q;
            if (rx_tog_s ^ rx_seen_q) begin
                rx_data <= rx_byte_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ur_seen_q   <= 1'b0;
            tx_underrun <= 1'b0;
        end else begin
            ur_seen_q   <= ur_tog_s;
            tx_underrun <= ur_tog_s ^ ur_seen_q;
        end
    end

    // frame edges as seen by the core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selected    <= 1'b0;
            frame_start <= 1'b0;
            frame_end   <= 1'b0;
        end else begin
            selected    <= ~cs_n_s;
            frame_start <= ~cs_n_s & ~selected;
            frame_end   <= cs_n_s & selected;
        end
    end

    // a pause only counts inside a frame; outside it the pin means nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            paused  <= 1'b0;
            wp_lock <= 1'b0;
        end else begin
            paused  <= ~cs_n_s & ~hold_n_s;
            wp_lock <= ~wp_n_s;
        end
    end

    // self-timed operation runs on the system clock and never looks at the pause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_cnt_q <= '0;
            op_busy  <= 1'b0;
        end else if (!op_busy) begin
            if (op_start) begin
                op_cnt_q <= '0;
                op_busy  <= 1'b1;
            end
        end else if (op_cnt_q == ($clog2(OP_CYCLES+1))'(OP_CYCLES - 1)) begin
            op_busy <= 1'b0;
        end else begin
            op_cnt_q <= op_cnt_q + 1'b1;
        end
    end

endmodule : sfp_pins

`default_nettype wire

// [src/sfp_defs.svh]
// constants shared by the serial pin interface block
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

`define SFP_BYTE_W        8
`define SFP_FIFO_DEPTH    4
`define SFP_LAST_SINGLE   3'h7
`define SFP_LAST_DUAL     3'h3
`define SFP_PIN_SYNC_RST  5'h07
`define SFP_MODE_SYNC_RST 2'h0
`define SFP_OP_CYCLES     1000

`endif

// [src/sfp_pkg.sv]
// types and shared helpers of the serial pin interface block
`include "sfp_defs.svh"

package sfp_pkg;

    // gray order along rx -> single out -> dual out; 2'b10 is never used
    typedef enum logic [1:0] {
        SFP_LK_RX  = 2'b00,
        SFP_LK_TX1 = 2'b01,
        SFP_LK_TX2 = 2'b11
    } sfp_link_st_t;

    typedef logic [`SFP_BYTE_W-1:0] sfp_byte_t;

    // last bit position of a byte: eight single edges or four dual edges
    function automatic logic [2:0] sfp_last_bit(input logic dual);
        sfp_last_bit = dual ? `SFP_LAST_DUAL : `SFP_LAST_SINGLE;
    endfunction : sfp_last_bit

endpackage : sfp_pkg

// [src/sfp_strm_if.sv]
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none

interface sfp_strm_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfp_strm_if

`default_nettype wire

// [src/sfp_sync.sv]
// three-stage pin synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module sfp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= (s2_q & agree) | (q & ~agree);
        end
    end
endmodule : sfp_sync

`default_nettype wire

// [src/sfp_afifo.sv]
// dual-clock word fifo with gray pointers and registered full and empty
`timescale 1ns/1ps
`default_nettype none

module sfp_afifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input wire logic   wr_clk,
    input wire logic   rd_clk,
    input wire logic   rst,
    sfp_strm_if.snk    wr,
    sfp_strm_if.src    rd
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wbin_q, wgray_q, rbin_q, rgray_q;
    logic [AW:0]  rg1_q, rg2_q, wg1_q, wg2_q;
    logic [AW:0]  wbin_d, rbin_d;
    logic         push, pop, ready_q, valid_q;

    assign push     = wr.valid & ready_q;
    assign pop      = valid_q & rd.ready;
    assign wbin_d   = wbin_q + {{AW{1'b0}}, push};
    assign rbin_d   = rbin_q + {{AW{1'b0}}, pop};
    assign wr.ready = ready_q;
    assign rd.valid = valid_q;
    assign rd.data  = mem[rbin_q[AW-1:0]];

    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem[wbin_q[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge wr_clk or posedge rst) begin
        if (rst) begin
            wbin_q  <= '0;
            wgray_q <= '0;
            rg1_q   <= '0;
            rg2_q   <= '0;
            ready_q <= 1'b0;
        end else begin
            wbin_q  <= wbin_d;
            wgray_q <= to_gray(wbin_d);
            rg1_q   <= rgray_q;
            rg2_q   <= rg1_q;
            ready_q <= to_gray(wbin_d) != {~rg2_q[AW:AW-1], rg2_q[AW-2:0]};
        end
    end

    always_ff @(posedge rd_clk or posedge rst) begin
        if (rst) begin
            rbin_q  <= '0;
            rgray_q <= '0;
            wg1_q   <= '0;
            wg2_q   <= '0;
            valid_q <= 1'b0;
        end else begin
            rbin_q  <= rbin_d;
            rgray_q <= to_gray(rbin_d);
            wg1_q   <= wgray_q;
            wg2_q   <= wg1_q;
            valid_q <= to_gray(rbin_d) != wg2_q;
        end
    end
endmodule : sfp_afifo

`default_nettype wire

// [sim/sfp_host_model.sv]
// spi host model: drives select, clock, pause and serial input, samples both data lines
`timescale 1ns/1ps
`default_nettype none

module sfp_host_model (
    output var  logic sck,
    output var  logic cs_n,
    output var  logic hold_n,
    output var  logic si,
    input  wire logic up,
    input  wire logic lo
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        hold_n = 1'b1;
        si = 1'b0;
    end

    task automatic open_frame();
        #7 cs_n = 1'b0;
        #16;
    endtask : open_frame

    task automatic close_frame();
        #16 cs_n = 1'b1;
        si = ~si; // released line must not keep its last value
        #16;
    endtask : close_frame

    // mode 0: data set while the clock is low, both lines sampled at the rise
    task automatic xfer(input logic [7:0] d, input int hi, input int n, inout logic [15:0] got);
        logic u;
        logic l;
        for (int i = hi; i > hi - n; i--) begin
            si = d[i];
            #16 sck = 1'b1;
            u = up;
            l = lo;
            got = {got[13:0], u, l};
            #16 sck = 1'b0;
        end
    endtask : xfer

    // changes only mid low phase, well away from any clock edge
    task automatic hold_set(input logic v);
        #8 hold_n = v;
        #8;
    endtask : hold_set

    // clock and data keep moving while paused, the device must ignore them
    task automatic spin(input int n);
        repeat (n) begin
            si = ~si;
            #16 sck = 1'b1;
            #16 sck = 1'b0;
        end
    endtask : spin
endmodule : sfp_host_model

`default_nettype wire

// [sim/sfp_pins_checker.sv]
// concurrent checks on the serial pin interface ports
`timescale 1ns/1ps
`default_nettype none

module sfp_pins_checker
    import sfp_pkg::*;
#(
    parameter int OP_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic dual_line_lower_o,
    input wire logic dual_line_lower_oe_n,
    input wire logic dual_line_upper_o,
    input wire logic dual_line_upper_oe_n,
    input wire logic tx_underrun,
    input wire logic selected,
    input wire logic paused,
    input wire logic wp_lock,
    input wire logic op_busy
);
    logic [15:0] busy_cnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= op_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    property p_oe_desel;
        @(posedge clk) disable iff (rst) cs_n |-> dual_line_upper_oe_n && dual_line_lower_oe_n;
    endproperty
    a_oe_desel: assert property (p_oe_desel) else $error("line driven while deselected");

    property p_oe_hold;
        @(posedge clk) disable iff (rst) !hold_n |-> dual_line_upper_oe_n && dual_line_lower_oe_n;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("line driven while paused");

    // at a fall the sampled clock is high: nothing may have moved since the rise
    property p_up_fall;
        @(sck) disable iff (rst || cs_n) sck |-> $stable(dual_line_upper_o);
    endproperty
    a_up_fall: assert property (p_up_fall) else $error("upper line moved on a rise");

    property p_lo_fall;
        @(sck) disable iff (rst || cs_n) sck |-> $stable(dual_line_lower_o);
    endproperty
    a_lo_fall: assert property (p_lo_fall) else $error("lower line moved on a rise");

    property p_hold_frz;
        @(sck) disable iff (rst || cs_n) !hold_n [*2] |-> $stable(dual_line_upper_o) && $stable(dual_line_lower_o);
    endproperty
    a_hold_frz: assert property (p_hold_frz) else $error("output shifted while paused");

    property p_pause;
        @(posedge clk) disable iff (rst) $fell(hold_n) && !cs_n |-> ##[1:6] paused && selected;
    endproperty
    a_pause: assert property (p_pause) else $error("pause not seen or select lost");

    property p_op_len;
        @(posedge clk) disable iff (rst) $fell(op_busy) && !$past(rst) |-> busy_cnt_q == 16'(OP_CYCLES);
    endproperty
    a_op_len: assert property (p_op_len) else $error("operation length wrong");

    property p_wp;
        @(posedge clk) disable iff (rst) $fell(wp_n) |-> ##[1:6] wp_lock;
    endproperty
    a_wp: assert property (p_wp) else $error("protect lock not raised");

    c_pause: cover property (@(posedge clk) disable iff (rst) paused);
    c_dual: cover property (@(posedge clk) disable iff (rst) !dual_line_lower_oe_n);
    c_under: cover property (@(posedge clk) disable iff (rst) tx_underrun);
endmodule : sfp_pins_checker

bind sfp_pins sfp_pins_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (
    .clk, .rst, .sck, .cs_n, .hold_n, .wp_n, .dual_line_lower_o, .dual_line_lower_oe_n, .dual_line_upper_o,
    .dual_line_upper_oe_n, .tx_underrun, .selected, .paused, .wp_lock, .op_busy
);

`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the serial pin interface against a host model
`timescale 1ns/1ps
`default_nettype none

module tb
    import sfp_pkg::*;
;
    localparam int OPC = 10;
    logic      clk = 1'b0;
    logic      rst = 1'b1;
    logic      wp_n = 1'b1;
    logic      out_mode = 1'b0;
    logic      dual_mode = 1'b0;
    logic      tx_valid = 1'b0;
    logic      op_start = 1'b0;
    logic      flt = 1'b0;
    sfp_byte_t tx_data = 8'h00;
    logic      sck, cs_n, hold_n, si, up_o, up_oe_n, lo_o, lo_oe_n;
    logic      tx_ready, rx_valid, tx_underrun, selected, paused, wp_lock, op_busy, fs, fe;
    int        n_fs = 0;
    int        n_fe = 0;
    sfp_byte_t rx_data, c, t;
    sfp_byte_t rx_q[$];
    sfp_byte_t tx_q[$];
    logic [15:0] g;
    int        n_mismatch = 0;
    int        checked = 0;
    int        n_under = 0;
    // an undriven upper line toggles so a stale value can never pass; an undriven lower line carries si
    wire logic up_w = up_oe_n ? flt : up_o;
    wire logic lo_w = lo_oe_n ? si : lo_o;

    sfp_pins #(.OP_CYCLES(OPC)) u_dut (
        .clk, .rst, .sck, .cs_n, .hold_n, .wp_n, .dual_line_lower_i(lo_w), .dual_line_lower_o(lo_o),
        .dual_line_lower_oe_n(lo_oe_n), .dual_line_upper_i(up_w), .dual_line_upper_o(up_o),
        .dual_line_upper_oe_n(up_oe_n), .out_mode, .dual_mode, .tx_data, .tx_valid, .tx_ready, .rx_data,
        .rx_valid, .tx_underrun, .frame_start(fs), .frame_end(fe), .selected, .paused, .wp_lock, .op_start, .op_busy
    );
    sfp_host_model u_host (.sck, .cs_n, .hold_n, .si, .up(up_w), .lo(lo_w));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        flt <= ~flt;
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (tx_underrun === 1'b1) n_under++;
        if (fs === 1'b1) n_fs++;
        if (fe === 1'b1) n_fe++;
    end

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_byte(input sfp_byte_t got, input sfp_byte_t exp);
        cmp_word({8'h00, got}, {8'h00, exp});
    endtask : cmp_byte
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_bit

    task automatic finish_test();
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // ready is sampled at the negedge, so the take edge is known without a race
    task automatic push(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            tx_q.push_back(8'($urandom()));
            tx_data <= tx_q[$];
            tx_valid <= 1'b1;
            r = 1'b0;
            for (int w = 0; w < 40 && !r; w++) begin
                @(negedge clk);
                r = (tx_ready === 1'b1);
                @(posedge clk);
            end
        end
        tx_valid <= 1'b0;
    endtask : push

    function automatic logic [15:0] spread(input sfp_byte_t b);
        spread = 16'h0000;
        for (int i = 7; i >= 0; i--) spread = {spread[13:0], b[i], b[i]};
    endfunction : spread

    // one frame: a received byte, then n queued bytes sent single or dual, one paused in single mode only
    task automatic send_frame(input int n, input logic dual);
        n_under = 0;
        n_fs = 0;
        n_fe = 0;
        rx_q.delete();
        c = 8'($urandom());
        u_host.open_frame();
        u_host.xfer(c, 7, 8, g);
        for (int i = 0; i < n; i++) begin
            t = tx_q.pop_front();
            g = 16'h0000;
            u_host.xfer(t, 7, dual ? 4 : 4, g);
            if (i == 1 && !dual) begin
                u_host.hold_set(1'b0);
                repeat (6) @(posedge clk);
                op_start <= 1'b1;
                @(posedge clk);
                op_start <= 1'b0;
                u_host.spin(2);
                cmp_bit(op_busy, 1'b1);
                u_host.hold_set(1'b1);
            end
            if (!dual) u_host.xfer(t, 3, 4, g);
            cmp_word(g, dual ? {8'h00, t} : spread(t));
        end
        u_host.close_frame();
        repeat (12) @(posedge clk);
        cmp_byte(rx_q[0], c);
        cmp_word(16'(n_under), 16'h0001);
        cmp_word(16'(n_fs), 16'h0001);
        cmp_word(16'(n_fe), 16'h0001);
        cmp_bit(tx_ready, 1'b1);
        cmp_bit(op_busy, 1'b0);
    endtask : send_frame

    initial begin
        #400000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        c = 8'($urandom(32'hd4b49026));
        repeat (5) @(posedge clk);
        cmp_bit(tx_ready, 1'b0);
        cmp_bit(up_oe_n & lo_oe_n, 1'b1);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // receive two bytes, paused mid byte, then a partial byte that must vanish
        c = 8'($urandom());
        t = 8'($urandom());
        u_host.open_frame();
        u_host.xfer(c, 7, 4, g);
        u_host.hold_set(1'b0);
        u_host.spin(3);
        repeat (8) @(posedge clk);
        cmp_bit(paused & selected, 1'b1);
        u_host.hold_set(1'b1);
        u_host.xfer(c, 3, 4, g);
        u_host.xfer(t, 7, 8, g);
        u_host.xfer(c, 7, 3, g);
        u_host.close_frame();
        repeat (12) @(posedge clk);
        cmp_word(16'(rx_q.size()), 16'h0002);
        cmp_byte(rx_q[0], c);
        cmp_byte(rx_q[1], t);
        // fill until refused, then drain with single output and an underrun
        push(4);
        repeat (2) @(negedge clk);
        cmp_bit(tx_ready, 1'b0);
        @(posedge clk);
        out_mode <= 1'b1;
        send_frame(4, 1'b0);
        @(posedge clk);
        dual_mode <= 1'b1;
        push(2);
        send_frame(2, 1'b1);
        out_mode <= 1'b0;
        dual_mode <= 1'b0;
        wp_n <= 1'b0;
        repeat (8) @(posedge clk);
        cmp_bit(wp_lock, 1'b1);
        wp_n <= 1'b1;
        repeat (8) @(posedge clk);
        cmp_bit(wp_lock, 1'b0);
        finish_test();
    end
endmodule : tb

`default_nettype wire
